// [wsrc_map.svh]
// Purpose: offsets, field positions, response codes and timing counts
// Assumes: 25 MHz system clock, AXI4-Lite byte addressing
// Notes:   included by the relay control module and the bench
`ifndef WSRC_MAP_SVH
`define WSRC_MAP_SVH

// register byte offsets
`define WSRC_CTRL_OFS      8'h00
`define WSRC_STATE_OFS     8'h04
`define WSRC_EDIT_OFS      8'h08
`define WSRC_SQZ_OFS       8'h0c
`define WSRC_WELD_OFS      8'h10
`define WSRC_HOLD_OFS      8'h14
`define WSRC_LEVEL_OFS     8'h18
`define WSRC_RELAY_OFS     8'h1c
`define WSRC_IRQ_STAT_OFS  8'h20
`define WSRC_IRQ_CLR_OFS   8'h24
`define WSRC_IRQ_EN_OFS    8'h28

// control fields
`define WSRC_CTRL_START    0
`define WSRC_CTRL_RUN      1
`define WSRC_CTRL_DUAL     2
`define WSRC_CTRL_SEL_LSB  8

// relay fields
`define WSRC_R1MODE_LSB    0
`define WSRC_R1PER_LSB     4
`define WSRC_R2PER_LSB     8

// level fields
`define WSRC_FB_LSB        16

// interrupt bits
`define WSRC_IRQ_DONE      0
`define WSRC_IRQ_ALARM     1
`define WSRC_IRQ_REJECT    2

// timing
`define WSRC_CLK_HZ        25000000
`define WSRC_EOP_MS        20
`define WSRC_SQZ_MAX_MS    2000

// answers for mapped and unmapped offsets
`define WSRC_RESP_OK       2'b00
`define WSRC_RESP_ERR      2'b10

`endif

// [wsrc_pkg.sv]
// Purpose: types shared by the status relay control
// Assumes: nothing beyond SystemVerilog
// Notes:   codes are written out for relay mode and feedback type; state is read by software but its codes are not written out
package wsrc_pkg;

  typedef enum {
    WSRC_IDLE,
    WSRC_SQUEEZE,
    WSRC_WELD,
    WSRC_HOLD
  } wsrc_state_t;

  // first relay mode as written by software
  typedef enum logic [2:0] {
    WSRC_R1_PERIOD  = 3'h0,
    WSRC_R1_RUNSTATE = 3'h1,
    WSRC_R1_ALARM_NO = 3'h2,
    WSRC_R1_ALARM_NC = 3'h3,
    WSRC_R1_ENDPROC = 3'h4,
    WSRC_R1_AIRHEAD2 = 3'h5,
    WSRC_R1_NOTUSED = 3'h6
  } wsrc_r1mode_t;

  typedef enum logic [1:0] {
    WSRC_FB_CURRENT = 2'h0,
    WSRC_FB_VOLTAGE = 2'h1,
    WSRC_FB_POWER   = 2'h2
  } wsrc_fb_t;

endpackage

// [wsrc_relay_ctrl.sv]
// Purpose: status relay and air valve control for a weld sequencer
// Assumes: AXI4-Lite master, start and alarm pulses from same-clock logic
// Notes:   schedules live in local arrays; the active one is latched at start
`include "wsrc_map.svh"

// What this block does
// - each relay switchable per squeeze, weld, hold
// - first relay offers whole-sequence modes
// - idle indication ignores weld and hold settings
// - idle indication: on only while no sequence runs
// - open-contact alarm: closes on any alarm
// - open-contact alarm reopens on run or start
// - closed-contact alarm: opens on any alarm
// - closed-contact alarm recloses on run or start
// - end-of-process: 20 ms pulse after last period
// - first relay mode ties to second air valve
// - dual air: only air head two or unused
// - dual air: second valve for air head two
// - dual air: first valve when relay unused
// - relay settings stored per schedule, applied on run
// - schedule holds feedback type, times, level
// - squeeze time accepted from 0 to 2000 ms
module wsrc_relay_ctrl #(
  parameter int NSCHED    = 16,
  parameter int IDXW      = 4,
  parameter int MS_CYCLES = `WSRC_CLK_HZ / 1000
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  clkEn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  seqStart,
  input  wire logic                  alarmRaise,
  output logic                       first_status_relay,
  output logic                       second_status_relay,
  output logic                       airValve1,
  output logic                       airValve2,
  output logic                       weldPeriod,
  output logic [15:0]                weldLevel,
  output wsrc_pkg::wsrc_fb_t         feedbackSel,
  output logic                       irq
);
  import wsrc_pkg::*;

  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  // per-schedule storage
  logic [10:0]  sqzTime   [NSCHED];
  logic [15:0]  weldTime  [NSCHED];
  logic [15:0]  holdTime  [NSCHED];
  logic [15:0]  levelMem  [NSCHED];
  wsrc_fb_t     fbMem     [NSCHED];
  wsrc_r1mode_t r1Mode    [NSCHED];
  logic [2:0]   r1Per     [NSCHED];
  logic [2:0]   r2Per     [NSCHED];

  logic [7:0]   awAddr_reg;
  logic [31:0]  wData_reg;
  logic [3:0]   wStrb_reg;
  logic         wrCommit;
  logic [31:0]  wrWord;
  logic         startReq;
  logic         runClear;
  logic         dualAir_reg;
  logic [IDXW-1:0] selIdx_reg;
  logic [IDXW-1:0] editIdx_reg;
  logic [IDXW-1:0] runIdx_reg;
  wsrc_state_t  state_reg;
  logic [15:0]  perCnt_reg;
  logic [31:0]  msCnt_reg;
  logic         msTick;
  logic         periodDone;
  logic         busy;
  logic [4:0]   eopCnt_reg;
  logic         eopOn;
  logic         alarm_reg;
  logic [2:0]   irqStat_reg;
  logic [2:0]   irqEn_reg;
  logic [2:0]   irqEvt;
  logic         rejectEvt;
  logic         relay1_next;
  logic         relay2_next;
  logic         valve1_next;
  logic         valve2_next;
  logic [2:0]   perBit;

  // byte-lane merge for partial writes
  function automatic logic [31:0] mergeStrb(input logic [31:0] oldW,
                                            input logic [31:0] newW,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = oldW;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newW[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // read view of every register, shared by reads and partial writes
  function automatic logic [31:0] readWord(input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0;
    case (addr)
      `WSRC_CTRL_OFS: begin
        v[`WSRC_CTRL_DUAL] = dualAir_reg;
        v[`WSRC_CTRL_SEL_LSB +: IDXW] = selIdx_reg;
      end
      `WSRC_STATE_OFS: begin
        v[1:0] = 2'(state_reg);
        v[2]   = alarm_reg;
        v[3]   = eopOn;
        v[4]   = first_status_relay;
        v[5]   = second_status_relay;
        v[6]   = airValve1;
        v[7]   = airValve2;
        v[8 +: IDXW] = runIdx_reg;
      end
      `WSRC_EDIT_OFS:     v[IDXW-1:0] = editIdx_reg;
      `WSRC_SQZ_OFS:      v[10:0] = sqzTime[editIdx_reg];
      `WSRC_WELD_OFS:     v[15:0] = weldTime[editIdx_reg];
      `WSRC_HOLD_OFS:     v[15:0] = holdTime[editIdx_reg];
      `WSRC_LEVEL_OFS: begin
        v[15:0] = levelMem[editIdx_reg];
        v[`WSRC_FB_LSB +: 2] = fbMem[editIdx_reg];
      end
      `WSRC_RELAY_OFS: begin
        v[`WSRC_R1MODE_LSB +: 3] = r1Mode[editIdx_reg];
        v[`WSRC_R1PER_LSB +: 3]  = r1Per[editIdx_reg];
        v[`WSRC_R2PER_LSB +: 3]  = r2Per[editIdx_reg];
      end
      `WSRC_IRQ_STAT_OFS: v[2:0] = irqStat_reg;
      `WSRC_IRQ_EN_OFS:   v[2:0] = irqEn_reg;
      default:            v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= `WSRC_IRQ_EN_OFS);
  endfunction

  // write channel: address and data taken in either order
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WSRC_RESP_OK;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h0;
      wStrb_reg     <= 4'h0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
      end
      if (wrCommit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_reg) ? `WSRC_RESP_OK : `WSRC_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // both halves held and no answer pending: the write takes effect now
  assign wrCommit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wrWord   = mergeStrb(readWord(awAddr_reg), wData_reg, wStrb_reg);

  // read channel: one-cycle registered answer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `WSRC_RESP_OK;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readWord(s_axi_araddr);
        s_axi_rresp   <= mapped(s_axi_araddr) ? `WSRC_RESP_OK : `WSRC_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // command bits are pulses, never stored
  assign startReq = seqStart
                  || (wrCommit && awAddr_reg == `WSRC_CTRL_OFS && wrWord[`WSRC_CTRL_START]);
  assign runClear = wrCommit && awAddr_reg == `WSRC_CTRL_OFS && wrWord[`WSRC_CTRL_RUN];

  // mode writes that dual air forbids are dropped and flagged
  assign rejectEvt = wrCommit && awAddr_reg == `WSRC_RELAY_OFS && dualAir_reg
                  && wrWord[`WSRC_R1MODE_LSB +: 3] != WSRC_R1_AIRHEAD2
                  && wrWord[`WSRC_R1MODE_LSB +: 3] != WSRC_R1_NOTUSED;

  // control and selection registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dualAir_reg <= 1'b0;
      selIdx_reg  <= '0;
      editIdx_reg <= '0;
      irqEn_reg   <= 3'h0;
    end else if (clkEn && wrCommit) begin
      case (awAddr_reg)
        `WSRC_CTRL_OFS: begin
          dualAir_reg <= wrWord[`WSRC_CTRL_DUAL];
          selIdx_reg  <= wrWord[`WSRC_CTRL_SEL_LSB +: IDXW];
        end
        `WSRC_EDIT_OFS:   editIdx_reg <= wrWord[IDXW-1:0];
        `WSRC_IRQ_EN_OFS: irqEn_reg   <= wrWord[2:0];
        default: ;
      endcase
    end
  end

  // schedule storage; reset clears every schedule to zero times, all off
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < NSCHED; i++) begin
        sqzTime[i]  <= 11'h0;
        weldTime[i] <= 16'h0;
        holdTime[i] <= 16'h0;
        levelMem[i] <= 16'h0;
        fbMem[i]    <= WSRC_FB_CURRENT;
        r1Mode[i]   <= WSRC_R1_PERIOD;
        r1Per[i]    <= 3'h0;
        r2Per[i]    <= 3'h0;
      end
    end else if (clkEn && wrCommit) begin
      case (awAddr_reg)
        `WSRC_SQZ_OFS: begin
          // longer squeeze requests saturate at the top of the range
          if (wrWord > 32'(`WSRC_SQZ_MAX_MS)) begin
            sqzTime[editIdx_reg] <= 11'(`WSRC_SQZ_MAX_MS);
          end else begin
            sqzTime[editIdx_reg] <= wrWord[10:0];
          end
        end
        `WSRC_WELD_OFS: weldTime[editIdx_reg] <= wrWord[15:0];
        `WSRC_HOLD_OFS: holdTime[editIdx_reg] <= wrWord[15:0];
        `WSRC_LEVEL_OFS: begin
          levelMem[editIdx_reg] <= wrWord[15:0];
          // unused feedback code 3 is kept as current
          if (wrWord[`WSRC_FB_LSB +: 2] == 2'h3) begin
            fbMem[editIdx_reg] <= WSRC_FB_CURRENT;
          end else begin
            fbMem[editIdx_reg] <= wsrc_fb_t'(wrWord[`WSRC_FB_LSB +: 2]);
          end
        end
        `WSRC_RELAY_OFS: begin
          r1Per[editIdx_reg] <= wrWord[`WSRC_R1PER_LSB +: 3];
          r2Per[editIdx_reg] <= wrWord[`WSRC_R2PER_LSB +: 3];
          if (!rejectEvt && wrWord[`WSRC_R1MODE_LSB +: 3] <= 3'(WSRC_R1_NOTUSED)) begin
            r1Mode[editIdx_reg] <= wsrc_r1mode_t'(wrWord[`WSRC_R1MODE_LSB +: 3]);
          end
        end
        default: ;
      endcase
    end
  end

  // millisecond timer, restarted at each period load so periods are exact
  assign msTick     = (msCnt_reg == MS_LAST);
  assign busy       = (state_reg != WSRC_IDLE);
  assign periodDone = busy && (perCnt_reg == 16'h0);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      msCnt_reg <= 32'h0;
    end else if (clkEn) begin
      if ((startReq && !busy) || periodDone || msTick) begin
        msCnt_reg <= 32'h0;
      end else begin
        msCnt_reg <= msCnt_reg + 32'h1;
      end
    end
  end

  // sequencer: squeeze, weld, hold in that order; a zero period takes one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg  <= WSRC_IDLE;
      perCnt_reg <= 16'h0;
      runIdx_reg <= '0;
    end else if (clkEn) begin
      case (state_reg)
        WSRC_IDLE: begin
          if (startReq) begin
            runIdx_reg <= selIdx_reg;
            perCnt_reg <= {5'h0, sqzTime[selIdx_reg]};
            state_reg  <= WSRC_SQUEEZE;
          end
        end
        WSRC_SQUEEZE: begin
          if (periodDone) begin
            perCnt_reg <= weldTime[runIdx_reg];
            state_reg  <= WSRC_WELD;
          end else if (msTick) begin
            perCnt_reg <= perCnt_reg - 16'h1;
          end
        end
        WSRC_WELD: begin
          if (periodDone) begin
            perCnt_reg <= holdTime[runIdx_reg];
            state_reg  <= WSRC_HOLD;
          end else if (msTick) begin
            perCnt_reg <= perCnt_reg - 16'h1;
          end
        end
        WSRC_HOLD: begin
          if (periodDone) begin
            state_reg <= WSRC_IDLE;
          end else if (msTick) begin
            perCnt_reg <= perCnt_reg - 16'h1;
          end
        end
        default: state_reg <= WSRC_IDLE;
      endcase
    end
  end

  // end-of-process pulse counts whole milliseconds after hold ends
  assign eopOn = (eopCnt_reg != 5'h0);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      eopCnt_reg <= 5'h0;
    end else if (clkEn) begin
      if (state_reg == WSRC_HOLD && periodDone) begin
        eopCnt_reg <= 5'(`WSRC_EOP_MS);
      end else if (eopOn && msTick) begin
        eopCnt_reg <= eopCnt_reg - 5'h1;
      end
    end
  end

  // alarm latch: a raise in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alarm_reg <= 1'b0;
    end else if (clkEn) begin
      if (alarmRaise) begin
        alarm_reg <= 1'b1;
      end else if (runClear || (startReq && !busy)) begin
        alarm_reg <= 1'b0;
      end
    end
  end

  // per-period enable bit for the current period
  always_comb begin
    case (state_reg)
      WSRC_SQUEEZE: perBit = 3'b001;
      WSRC_WELD:    perBit = 3'b010;
      WSRC_HOLD:    perBit = 3'b100;
      default:      perBit = 3'b000;
    endcase
  end

  // relay and valve decisions from the running schedule
  always_comb begin
    relay2_next = |(perBit & r2Per[runIdx_reg]);
    valve1_next = busy && (!dualAir_reg || r1Mode[runIdx_reg] == WSRC_R1_NOTUSED);
    valve2_next = busy && dualAir_reg && r1Mode[runIdx_reg] == WSRC_R1_AIRHEAD2;
    case (r1Mode[runIdx_reg])
      WSRC_R1_PERIOD:   relay1_next = |(perBit & r1Per[runIdx_reg]);
      // weld and hold bits are not consulted here
      WSRC_R1_RUNSTATE: relay1_next = !busy;
      WSRC_R1_ALARM_NO: relay1_next = alarm_reg;
      WSRC_R1_ALARM_NC: relay1_next = !alarm_reg;
      WSRC_R1_ENDPROC:  relay1_next = eopOn;
      WSRC_R1_AIRHEAD2: relay1_next = valve2_next;
      default:          relay1_next = 1'b0;
    endcase
  end

  // outputs straight from flops; one cycle behind the decisions
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      first_status_relay  <= 1'b0;
      second_status_relay <= 1'b0;
      airValve1           <= 1'b0;
      airValve2           <= 1'b0;
      weldPeriod          <= 1'b0;
      weldLevel           <= 16'h0;
      feedbackSel         <= WSRC_FB_CURRENT;
    end else if (clkEn) begin
      first_status_relay  <= relay1_next;
      second_status_relay <= relay2_next;
      airValve1           <= valve1_next;
      airValve2           <= valve2_next;
      weldPeriod          <= (state_reg == WSRC_WELD);
      weldLevel           <= levelMem[runIdx_reg];
      feedbackSel         <= fbMem[runIdx_reg];
    end
  end

  // sticky events; set wins over a clear in the same cycle
  assign irqEvt[`WSRC_IRQ_DONE]   = (state_reg == WSRC_HOLD) && periodDone;
  assign irqEvt[`WSRC_IRQ_ALARM]  = alarmRaise;
  assign irqEvt[`WSRC_IRQ_REJECT] = rejectEvt;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqStat_reg <= 3'h0;
      irq         <= 1'b0;
    end else if (clkEn) begin
      if (wrCommit && awAddr_reg == `WSRC_IRQ_CLR_OFS) begin
        irqStat_reg <= (irqStat_reg & ~wrWord[2:0]) | irqEvt;
      end else begin
        irqStat_reg <= irqStat_reg | irqEvt;
      end
      irq <= |(irqStat_reg & irqEn_reg);
    end
  end

endmodule

// [wsrc_relay_chk.sv]
// Purpose: port-level checks on the status relay control
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into the relay control
module wsrc_relay_chk (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        clkEn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        first_status_relay,
  input wire logic        airValve1,
  input wire logic        airValve2,
  input wire logic        weldPeriod
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // outputs quiet out of reset
  property p_rst_quiet;
    $fell(reset) |-> !first_status_relay && !airValve1 && !airValve2 && !weldPeriod;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  // write answered two edges after take
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clkEn
      |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late or early");
  property p_b_done;
    s_axi_bvalid && s_axi_bready && clkEn |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready && clkEn |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_rd_done;
    s_axi_rvalid && s_axi_rready && clkEn |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read data not retired");
  // offsets past the map refused
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && clkEn && s_axi_araddr > 8'h28
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  // one schedule drives one valve, never both
  property p_valves;
    !(airValve1 && airValve2);
  endproperty
  a_valves: assert property (p_valves) else $error("both air valves driven");
  // enable low freezes outputs
  property p_freeze;
    !clkEn |=> $stable(first_status_relay) && $stable(weldPeriod) && $stable(airValve1);
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved with enable low");
  // weld periods never back to back
  property p_weld_gap;
    $fell(weldPeriod) |-> !weldPeriod [*2];
  endproperty
  a_weld_gap: assert property (p_weld_gap) else $error("weld restarted too soon");
endmodule

bind wsrc_relay_ctrl wsrc_relay_chk u_chk (.*);

// [wsrc_plc_model.sv]
// Purpose: line controller reading the two relay contacts
// Assumes: contacts sampled on the system clock
// Notes:   counts closed-contact cycles since the last clear
module wsrc_plc_model (
  input wire logic sys_clk,
  input wire logic clrCnt,
  input wire logic first_status_relay,
  input wire logic second_status_relay,
  output int       relay1Cnt,
  output int       relay2Cnt
);
  // raw count, no input filter, so a short glitch is not hidden
  always_ff @(posedge sys_clk) begin
    if (clrCnt) begin
      relay1Cnt <= 0;
      relay2Cnt <= 0;
    end else begin
      relay1Cnt <= relay1Cnt + int'(first_status_relay === 1'b1);
      relay2Cnt <= relay2Cnt + int'(second_status_relay === 1'b1);
    end
  end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the status relay control
// Assumes: 1 ms shortened to 4 cycles
// Notes:   schedule 3 runs as 2, 3 and 2 ms in every scenario
`include "wsrc_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wsrc_pkg::*;
  localparam int MS = 4;
  localparam int BUSY = 7 * MS + 3;
  localparam int RUNCYC = 125;
  logic        sys_clk, reset, clkEn, seqStart, alarmRaise, clrCnt, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ctrlBase, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        first_status_relay, second_status_relay, airValve1, airValve2, weldPeriod;
  logic [15:0] weldLevel;
  wsrc_fb_t    feedbackSel;
  int          fails, totalChecks, weldCnt, v1Cnt, v2Cnt, relay1Cnt, relay2Cnt;

  wsrc_relay_ctrl #(.MS_CYCLES(MS)) dut (.*);
  wsrc_plc_model plc (.*);

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // handshakes judged at the falling edge, where the outputs are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awT, wT, bT;
    int n;
    n = 0;
    bT = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!bT && n < 40) begin
      @(negedge sys_clk);
      n++;
      awT = s_axi_awready;
      wT = s_axi_wready;
      bT = (s_axi_bvalid === 1'b1);
      rsp = s_axi_bresp;
      @(posedge sys_clk);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!bT) chk("bus_wait", 0, 1);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic arT, rT;
    int n;
    n = 0;
    rT = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!rT && n < 40) begin
      @(negedge sys_clk);
      n++;
      arT = s_axi_arready;
      rT = (s_axi_rvalid === 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
      if (arT) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!rT) chk("bus_wait", 0, 1);
  endtask
  task automatic alarm;
    @(posedge sys_clk);
    alarmRaise <= 1'b1;
    @(posedge sys_clk);
    alarmRaise <= 1'b0;
    tick(3);
  endtask
  task automatic run_seq(input bit viaReg);
    @(posedge sys_clk);
    clrCnt <= 1'b1;
    seqStart <= !viaReg;
    @(posedge sys_clk);
    clrCnt <= 1'b0;
    seqStart <= 1'b0;
    weldCnt = 0;
    v1Cnt = 0;
    v2Cnt = 0;
    if (viaReg) wr(`WSRC_CTRL_OFS, ctrlBase | 32'h1);
    repeat (RUNCYC) begin
      @(negedge sys_clk);
      weldCnt += int'(weldPeriod === 1'b1);
      v1Cnt += int'(airValve1 === 1'b1);
      v2Cnt += int'(airValve2 === 1'b1);
    end
    @(negedge sys_clk);
  endtask
  task automatic t_regs;
    rdr(`WSRC_IRQ_EN_OFS);
    chk("irq_en_reset", 0, rd);
    rdr(8'h30);
    chk("unmapped_rresp", `WSRC_RESP_ERR, rsp);
    wr(8'h30, 32'hffff);
    chk("unmapped_bresp", `WSRC_RESP_ERR, rsp);
    wr(`WSRC_EDIT_OFS, 3);
    wr(`WSRC_SQZ_OFS, 2001);
    rdr(`WSRC_SQZ_OFS);
    chk("sqz_top", `WSRC_SQZ_MAX_MS, rd);
    wr(`WSRC_SQZ_OFS, 0);
    rdr(`WSRC_SQZ_OFS);
    chk("sqz_zero", 0, rd);
    wr(`WSRC_LEVEL_OFS, 32'h3_0abc);
    rdr(`WSRC_LEVEL_OFS);
    chk("fb_unused_code", 32'h0abc, rd);
    wr(`WSRC_SQZ_OFS, 2);
    wr(`WSRC_WELD_OFS, 3);
    wr(`WSRC_HOLD_OFS, 2);
    wr(`WSRC_LEVEL_OFS, 32'h1_0abc);
    wr(`WSRC_CTRL_OFS, ctrlBase);
    $display("registers test done");
  endtask
  task automatic t_period;
    wr(`WSRC_RELAY_OFS, 32'h520);  // relay 1 in weld, relay 2 in squeeze and hold
    run_seq(1'b0);
    chk("weld_cycles", 3 * MS + 1, weldCnt);
    chk("relay1_cycles", 3 * MS + 1, relay1Cnt);
    chk("relay2_cycles", 4 * MS + 2, relay2Cnt);
    chk("weld_level", 16'h0abc, weldLevel);
    chk("feedback", WSRC_FB_VOLTAGE, feedbackSel);
    $display("period test done");
  endtask
  task automatic t_idle;
    wr(`WSRC_RELAY_OFS, 32'h61);  // weld and hold bits must be ignored
    @(posedge sys_clk);
    clkEn <= 1'b0;
    tick(3);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    tick(1);
    chk("relay1_idle", 1, first_status_relay);
    run_seq(1'b0);
    chk("relay1_idle_cycles", RUNCYC - BUSY, relay1Cnt);
    $display("idle indication test done");
  endtask
  task automatic t_alarm(input wsrc_r1mode_t m);
    logic nc;
    nc = (m == WSRC_R1_ALARM_NC);
    wr(`WSRC_RELAY_OFS, m);
    tick(2);
    chk("relay1_no_alarm", nc, first_status_relay);
    alarm;
    chk("relay1_alarm", !nc, first_status_relay);
    wr(`WSRC_CTRL_OFS, ctrlBase | 32'h2);
    tick(2);
    chk("relay1_run_clear", nc, first_status_relay);
    alarm;
    run_seq(1'b0);
    chk("relay1_start_clear", nc, first_status_relay);
    $display("alarm test done");
  endtask
  task automatic t_irq;
    wr(`WSRC_IRQ_EN_OFS, 32'h2);
    alarm;
    chk("irq_set", 1, irq);
    wr(`WSRC_IRQ_EN_OFS, 0);
    tick(2);
    chk("irq_masked", 0, irq);
    wr(`WSRC_IRQ_EN_OFS, 32'h2);
    tick(2);
    chk("irq_unmasked", 1, irq);
    wr(`WSRC_IRQ_CLR_OFS, 32'h2);
    tick(2);
    chk("irq_cleared", 0, irq);
    $display("interrupt test done");
  endtask
  task automatic t_endproc;
    wr(`WSRC_RELAY_OFS, WSRC_R1_ENDPROC);
    run_seq(1'b1);
    chk("end_pulse", `WSRC_EOP_MS * MS, relay1Cnt);
    rdr(`WSRC_IRQ_STAT_OFS);
    chk("done_flag", 1, rd[0]);
    $display("end of process test done");
  endtask
  task automatic t_dual;
    ctrlBase = 32'h304;
    wr(`WSRC_CTRL_OFS, ctrlBase);
    wr(`WSRC_RELAY_OFS, WSRC_R1_RUNSTATE);
    rdr(`WSRC_RELAY_OFS);
    chk("mode_kept", WSRC_R1_ENDPROC, rd[2:0]);
    rdr(`WSRC_IRQ_STAT_OFS);
    chk("reject_flag", 1, rd[2]);
    for (int i = 5; i < 7; i++) begin
      wr(`WSRC_RELAY_OFS, i);
      run_seq(1'b0);
      chk("valve2_cycles", (i == 5) ? BUSY : 0, v2Cnt);
      chk("valve1_cycles", (i == 6) ? BUSY : 0, v1Cnt);
      chk("relay1_air_cycles", (i == 5) ? BUSY : 0, relay1Cnt);
    end
    $display("dual air test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // 40 ns period
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // only a hang gets this far
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    final_report;
  end
  initial begin
    {reset, clkEn} = 2'b11;
    {seqStart, alarmRaise, clrCnt} = 3'b000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    ctrlBase = 32'h300;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    t_period;
    t_idle;
    t_alarm(WSRC_R1_ALARM_NO);
    t_alarm(WSRC_R1_ALARM_NC);
    t_irq;
    t_endproc;
    t_dual;
    final_report;
  end
endmodule
